// [logic/sprm_pkg.sv]
// Purpose: Constants and types for the serial pin remap and converter routing block.
// Assumes: APB slave with 32-bit data, one word per register.
// Notes:   Offsets are byte addresses.
package sprm_pkg;
  localparam logic [11:0] SPRM_CFG2_ADDR  = 12'h000;
  localparam logic [11:0] SPRM_CFG3_ADDR  = 12'h004;
  localparam logic [11:0] SPRM_SELL_ADDR  = 12'h008;
  localparam logic [11:0] SPRM_SELH_ADDR  = 12'h00C;
  localparam logic [11:0] SPRM_STAT_ADDR  = 12'h010;
  localparam int          SPRM_B0_BIT     = 0;
  localparam int          SPRM_A_BIT      = 0;
  localparam int          SPRM_TB_BIT     = 1;
  localparam int          SPRM_ADCSEL_LSB = 8;
  localparam int          SPRM_ADCSEL_W   = 10;
  localparam int          SPRM_EXT_CH     = 10;
  localparam logic [3:0]  SPRM_CH_TEMP    = 4'hC;
  localparam logic [3:0]  SPRM_CH_VREF    = 4'hD;
  localparam logic [31:0] SPRM_RESET_VAL  = 32'h0000_0000;
  localparam logic [31:0] SPRM_ERR_VAL    = 32'h0000_0000;
  typedef enum logic [1:0] {
    SPRM_IDLE   = 2'b00,
    SPRM_ACCESS = 2'b01
  } sprm_phase_e;
endpackage : sprm_pkg

// [logic/sprm_route_if.sv]
`timescale 1ns/1ns
// Purpose: Carries relocation selects and converter pin selects to the router.
// Assumes: Selects are registered by the owner.
// Notes:   None.
interface sprm_route_if;
  logic        b0_reloc;
  logic        a_reloc;
  logic        tb_reloc;
  logic        cfg_variant;
  logic [9:0]  adc_pins;
  logic [7:0]  port1_adc;
  logic [7:0]  port2_adc;
  modport owner  (output b0_reloc, a_reloc, tb_reloc, cfg_variant, adc_pins, input port1_adc, port2_adc);
  modport router (input b0_reloc, a_reloc, tb_reloc, cfg_variant, adc_pins, output port1_adc, port2_adc);
endinterface : sprm_route_if

// [logic/sprm_adc_router.sv]
`timescale 1ns/1ns
// Purpose: Chooses which port pins act as converter analog inputs.
// Assumes: Channels 0 to 7 sit on port 1, 8 and 9 on port 2 pins 0 and 1.
// Notes:   Purely combinational.
module sprm_adc_router
  import sprm_pkg::*;
(
  // Selects.
  sprm_route_if.router rt
);
  always_comb begin
    rt.port1_adc = rt.adc_pins[7:0];
    rt.port2_adc = {6'h00, rt.adc_pins[9:8]};
  end
endmodule : sprm_adc_router

// [logic/sprm_top.sv]
`timescale 1ns/1ns
// Purpose: Pin relocation for serial units and timer outputs, converter input routing.
// Assumes: Inputs synchronous to pclk; pin directions are decided by the units.
// Notes:   Function
// Function
// - B0 signals to P1.0-3 or P2.2-5
// - Only one candidate group active per unit
// - Serial A between P1.4-7 and P1.0-3
// - Timer outputs between P1.6-7 and P2.0-1
// - A: SPI, UART, IrDA; B: SPI, I2C
// - Converter pins from config or port selects
// - Ten external plus two internal channels
// - Channel 12 temperature, channel 13 reference
module sprm_top
  import sprm_pkg::*;
(
  // APB.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // Variant strap: high when the second config register owns converter pin choice.
  input  wire logic        cfg_variant,
  // Serial B0 signals (select, clock, data out, data in; I2C uses the data pair).
  input  wire logic [3:0]  b0_out,
  input  wire logic [3:0]  b0_oe,
  output logic      [3:0]  b0_in,
  // Serial A signals (data out, data in, clock, select).
  input  wire logic [3:0]  a_out,
  input  wire logic [3:0]  a_oe,
  output logic      [3:0]  a_in,
  input  wire logic        a_mode_irda,
  // Timer outputs.
  input  wire logic [1:0]  tb_out,
  // Port pins.
  input  wire logic [7:0]  p1_in,
  input  wire logic [7:0]  p2_in,
  output logic      [7:0]  p1_out,
  output logic      [7:0]  p1_oe,
  output logic      [7:0]  p2_out,
  output logic      [7:0]  p2_oe,
  // Converter routing.
  input  wire logic [3:0]  adc_channel,
  output logic      [7:0]  p1_analog,
  output logic      [7:0]  p2_analog,
  output logic             adc_ch_valid,
  output logic             adc_ch_temp,
  output logic             adc_ch_vref
);
  typedef struct packed {
    logic [31:0] cfg2;
    logic [31:0] cfg3;
    logic [7:0]  sel_low;
    logic [7:0]  sel_high;
    logic [31:0] rdata;
  } sprm_state_s;

  sprm_state_s state_reg;
  sprm_state_s state_next;
  sprm_route_if rt ();

  function automatic logic [3:0] sprm_pick(input logic sel, input logic [3:0] x, input logic [3:0] y);
    sprm_pick = sel ? y : x;
  endfunction : sprm_pick

  // Serial A runs its bit 0 (data out) to the highest pin of either group, so its lines are mirrored.
  function automatic logic [3:0] sprm_rev(input logic [3:0] x);
    sprm_rev = {x[0], x[1], x[2], x[3]};
  endfunction : sprm_rev

  logic setup_wr;
  logic setup_rd;
  logic hit;
  assign hit      = (paddr == SPRM_CFG2_ADDR) || (paddr == SPRM_CFG3_ADDR) || (paddr == SPRM_SELL_ADDR)
                    || (paddr == SPRM_SELH_ADDR) || (paddr == SPRM_STAT_ADDR);
  assign setup_wr = psel && !penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;
  assign prdata   = state_reg.rdata;

  always_comb begin
    state_next = state_reg;
    if (psel && penable && pwrite) begin
      case (paddr)
        SPRM_CFG2_ADDR: state_next.cfg2 = pwdata;
        SPRM_CFG3_ADDR: state_next.cfg3 = pwdata;
        SPRM_SELL_ADDR: state_next.sel_low = pwdata[7:0];
        SPRM_SELH_ADDR: state_next.sel_high = pwdata[7:0];
        default: state_next.cfg2 = state_reg.cfg2;
      endcase
    end
    if (setup_rd) begin
      case (paddr)
        SPRM_CFG2_ADDR: state_next.rdata = state_reg.cfg2;
        SPRM_CFG3_ADDR: state_next.rdata = state_reg.cfg3;
        SPRM_SELL_ADDR: state_next.rdata = {24'h000000, state_reg.sel_low};
        SPRM_SELH_ADDR: state_next.rdata = {24'h000000, state_reg.sel_high};
        SPRM_STAT_ADDR: state_next.rdata = {16'h0000, p2_analog, p1_analog};
        default:        state_next.rdata = SPRM_ERR_VAL;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Converter pin-choice source depends on variant; the port selects are the fallback.
  assign rt.b0_reloc    = state_reg.cfg2[SPRM_B0_BIT];
  assign rt.a_reloc     = state_reg.cfg3[SPRM_A_BIT];
  assign rt.tb_reloc    = state_reg.cfg3[SPRM_TB_BIT];
  assign rt.cfg_variant = cfg_variant;
  assign rt.adc_pins    = cfg_variant ? state_reg.cfg2[SPRM_ADCSEL_LSB +: SPRM_ADCSEL_W]
                                      : {state_reg.sel_high[1:0], state_reg.sel_low & state_reg.sel_high};

  sprm_adc_router u_router (
    .rt (rt.router)
  );

  assign p1_analog = rt.port1_adc;
  assign p2_analog = rt.port2_adc;

  // Serial A and B0 share P1.0-3 when A relocates and B0 does not; A takes priority there.
  always_comb begin
    p1_out = 8'h00;
    p1_oe  = 8'h00;
    p2_out = 8'h00;
    p2_oe  = 8'h00;
    if (!rt.b0_reloc) begin
      p1_out[3:0] = b0_out;
      p1_oe[3:0]  = b0_oe;
    end else begin
      p2_out[5:2] = b0_out;
      p2_oe[5:2]  = b0_oe;
    end
    if (!rt.a_reloc) begin
      p1_out[7:4] = sprm_rev(a_out);
      p1_oe[7:4]  = sprm_rev(a_oe);
    end else begin
      p1_out[3:0] = sprm_rev(a_out);
      p1_oe[3:0]  = sprm_rev(a_oe);
    end
    if (!rt.tb_reloc) begin
      p1_out[7:6] = tb_out;
      p1_oe[7:6]  = 2'b11;
    end else begin
      p2_out[1:0] = tb_out;
      p2_oe[1:0]  = 2'b11;
    end
  end

  // Inputs come only from the active group; IrDA uses the same data pins.
  assign b0_in = sprm_pick(rt.b0_reloc, p1_in[3:0], p2_in[5:2]);
  assign a_in  = sprm_rev(sprm_pick(rt.a_reloc, p1_in[7:4], p1_in[3:0])) & {3'b111, !a_mode_irda};

  assign adc_ch_temp  = (adc_channel == SPRM_CH_TEMP);
  assign adc_ch_vref  = (adc_channel == SPRM_CH_VREF);
  assign adc_ch_valid = (adc_channel < 4'(SPRM_EXT_CH)) || adc_ch_temp || adc_ch_vref;

  property p_b0_default;
    @(posedge pclk) disable iff (!presetn) !rt.b0_reloc |-> (p1_oe[3:0] == b0_oe || rt.a_reloc) && p2_oe[5:2] == 4'h0;
  endproperty
  a_b0_default: assert property (p_b0_default) else $error("B0 default group wrong");
  property p_b0_moved;
    @(posedge pclk) disable iff (!presetn) rt.b0_reloc |-> p2_oe[5:2] == b0_oe && b0_in == p2_in[5:2];
  endproperty
  a_b0_moved: assert property (p_b0_moved) else $error("B0 relocated group wrong");
  property p_a_moved;
    @(posedge pclk) disable iff (!presetn)
      rt.a_reloc |-> p1_oe[3:0] == sprm_rev(a_oe) && a_in[3:1] == {p1_in[0], p1_in[1], p1_in[2]};
  endproperty
  a_a_moved: assert property (p_a_moved) else $error("Serial A relocated group wrong");
  property p_tb;
    @(posedge pclk) disable iff (!presetn) rt.tb_reloc |-> p2_oe[1:0] == 2'b11 && p2_out[1:0] == tb_out;
  endproperty
  a_tb: assert property (p_tb) else $error("Timer output relocation wrong");
  property p_cfg2_write;
    @(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && paddr == SPRM_CFG2_ADDR |=> rt.b0_reloc == $past(pwdata[SPRM_B0_BIT]);
  endproperty
  a_cfg2_write: assert property (p_cfg2_write) else $error("B0 relocate bit not written");
  property p_reset;
    @(posedge pclk) $rose(presetn) |-> !rt.b0_reloc && !rt.a_reloc && !rt.tb_reloc;
  endproperty
  a_reset: assert property (p_reset) else $error("Relocate bits not zero after reset");
  property p_temp;
    @(posedge pclk) disable iff (!presetn) adc_channel == 4'hC |-> adc_ch_valid && adc_ch_temp && !adc_ch_vref;
  endproperty
  a_temp: assert property (p_temp) else $error("Temperature channel wrong");
  property p_ext;
    @(posedge pclk) disable iff (!presetn) adc_channel inside {4'hA, 4'hB, 4'hE, 4'hF} |-> !adc_ch_valid;
  endproperty
  a_ext: assert property (p_ext) else $error("Channel count wrong");
  property p_adc_sel;
    @(posedge pclk) disable iff (!presetn) cfg_variant |-> p1_analog == state_reg.cfg2[15:8];
  endproperty
  a_adc_sel: assert property (p_adc_sel) else $error("Converter pin select wrong");
  property p_a_default;
    @(posedge pclk) disable iff (!presetn)
      !rt.a_reloc && rt.tb_reloc |-> p1_oe[7:4] == sprm_rev(a_oe) && a_in[3:2] == {p1_in[4], p1_in[5]};
  endproperty
  a_a_default: assert property (p_a_default) else $error("Serial A default group wrong");
  property p_b0_in_default;
    @(posedge pclk) disable iff (!presetn) !rt.b0_reloc |-> b0_in == p1_in[3:0] && p2_out[5:2] == 4'h0;
  endproperty
  a_b0_in_default: assert property (p_b0_in_default) else $error("B0 inputs not from default group");
  property p_vref;
    @(posedge pclk) disable iff (!presetn) adc_channel == SPRM_CH_VREF |-> adc_ch_valid && adc_ch_vref && !adc_ch_temp;
  endproperty
  a_vref: assert property (p_vref) else $error("Reference channel wrong");
  // A completed write to the third config register must move both relocation bits on the next edge.
  sequence s_cfg3_wr;
    psel && penable && pwrite && pready && paddr == SPRM_CFG3_ADDR;
  endsequence
  property p_cfg3_write;
    @(posedge pclk) disable iff (!presetn)
      s_cfg3_wr |=> rt.a_reloc == $past(pwdata[SPRM_A_BIT]) && rt.tb_reloc == $past(pwdata[SPRM_TB_BIT]);
  endproperty
  a_cfg3_write: assert property (p_cfg3_write) else $error("Config3 relocate bits not written");
endmodule : sprm_top

// [test/sprm_board.sv]
// Purpose: Board model behind the port pins.
// Assumes: Undriven pins show the board pattern.
// Notes:   A pin the device drives reads back its own level.
`timescale 1ns/1ns
module sprm_board (
  // Device side.
  input  wire logic [7:0] p1_out,
  input  wire logic [7:0] p1_oe,
  input  wire logic [7:0] p2_out,
  input  wire logic [7:0] p2_oe,
  // Board pattern.
  input  wire logic [7:0] ext1,
  input  wire logic [7:0] ext2,
  // Resolved levels.
  output logic      [7:0] p1_in,
  output logic      [7:0] p2_in
);
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & ext1);
  assign p2_in = (p2_oe & p2_out) | (~p2_oe & ext2);
endmodule : sprm_board

// [test/serial_pin_remap_and_adc_routing_tb.sv]
// Purpose: Random and corner checks of pin relocation and converter routing.
// Assumes: Timer output bit 0 sits on the lower pin of its pair.
// Notes:   Output values are compared only where the enable is high.
`timescale 1ns/1ns
module serial_pin_remap_and_adc_routing_tb;
  import sprm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cfg_variant, a_mode_irda, err;
  logic        adc_ch_valid, adc_ch_temp, adc_ch_vref;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c2, c3, sl, sh;
  logic [3:0]  b0_out, b0_oe, b0_in, a_out, a_oe, a_in, adc_channel;
  logic [1:0]  tb_out;
  logic [7:0]  p1_in, p2_in, p1_out, p1_oe, p2_out, p2_oe, p1_analog, p2_analog, ext1, ext2;
  int          err_total, n_tests;
  sprm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .cfg_variant(cfg_variant), .b0_out(b0_out), .b0_oe(b0_oe), .b0_in(b0_in), .a_out(a_out),
    .a_oe(a_oe), .a_in(a_in), .a_mode_irda(a_mode_irda), .tb_out(tb_out), .p1_in(p1_in), .p2_in(p2_in),
    .p1_out(p1_out), .p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe), .adc_channel(adc_channel),
    .p1_analog(p1_analog), .p2_analog(p2_analog), .adc_ch_valid(adc_ch_valid),
    .adc_ch_temp(adc_ch_temp), .adc_ch_vref(adc_ch_vref));
  sprm_board board (.p1_out(p1_out), .p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe),
    .ext1(ext1), .ext2(ext2), .p1_in(p1_in), .p2_in(p2_in));
  function automatic logic [3:0] rev(input logic [3:0] x);
    return {x[0], x[1], x[2], x[3]};
  endfunction : rev
  function automatic logic [15:0] adc_exp(input logic v, input logic [31:0] c, input logic [31:0] l,
                                          input logic [31:0] h);
    return v ? {6'h00, c[17:8]} : {6'h00, h[1:0], l[7:0] & h[7:0]};
  endfunction : adc_exp
  task automatic end_sim;
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Expected pin use is rebuilt from the written selects, never from the outputs.
  task automatic pins;
    @(negedge pclk);
    if (c2[0]) begin
      chk("b0 p2", {b0_oe, b0_out & b0_oe, b0_in}, {p2_oe[5:2], p2_out[5:2] & p2_oe[5:2], p2_in[5:2]});
      if (!c3[0]) chk("p1 low idle", 32'h0, 32'(p1_oe[3:0]));
    end else if (!c3[0]) begin
      chk("b0 p1", {b0_oe, b0_out & b0_oe, b0_in}, {p1_oe[3:0], p1_out[3:0] & p1_oe[3:0], p1_in[3:0]});
      chk("p2 b0 idle", 32'h0, 32'(p2_oe[5:2]));
    end
    if (c3[0]) begin
      chk("a low", {rev(a_oe), rev(a_out & a_oe), rev(p1_in[3:0]) & {3'b111, ~a_mode_irda}},
        {p1_oe[3:0], p1_out[3:0] & p1_oe[3:0], a_in});
      if (c3[1]) chk("p1 high idle", 32'h0, 32'(p1_oe[7:4]));
    end else begin
      chk("a in high", 32'({p1_in[4], p1_in[5]}), 32'(a_in[3:2]));
      if (c3[1]) chk("a high", 32'(rev(a_oe)), 32'(p1_oe[7:4]));
    end
    if (c3[1]) chk("tb p2", 32'(tb_out), 32'(p2_out[1:0]));
    else chk("tb p1", 32'(tb_out), 32'(p1_out[7:6]));
    if (cfg_variant) chk("adc cfg", 32'(adc_exp(1'b1, c2, sl, sh)), 32'({p2_analog, p1_analog}));
    else chk("adc sel", 32'(adc_exp(1'b0, c2, sl, sh)), 32'({p2_analog, p1_analog}));
  endtask : pins
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cfg_variant, a_mode_irda} = '0;
    {b0_out, b0_oe, a_out, a_oe, tb_out, adc_channel, ext1, ext2} = '0;
    {c2, c3, sl, sh, err_total, n_tests} = '0;
    void'($urandom(96));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SPRM_CFG2_ADDR, 32'h0);
    chk("cfg2 reset", 32'h0, rd);
    apb(1'b0, SPRM_CFG3_ADDR, 32'h0);
    chk("cfg3 reset", 32'h0, rd);
    pins();
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    for (int i = 0; i < 16; i++) begin
      @(posedge pclk);
      adc_channel <= i[3:0];
      @(negedge pclk);
      chk("channel", 32'({i < 10 || i == 12 || i == 13, i == 12, i == 13}),
        32'({adc_ch_valid, adc_ch_temp, adc_ch_vref}));
    end
    for (int n = 0; n < 40; n++) begin
      {c2, c3, sl, sh} = {$urandom, $urandom, $urandom, $urandom};
      @(posedge pclk);
      {b0_out, b0_oe, a_out, a_oe} <= 16'($urandom);
      {tb_out, cfg_variant, a_mode_irda, ext1, ext2} <= 20'($urandom);
      apb(1'b1, SPRM_CFG2_ADDR, c2);
      apb(1'b1, SPRM_CFG3_ADDR, c3);
      apb(1'b1, SPRM_SELL_ADDR, sl);
      apb(1'b1, SPRM_SELH_ADDR, sh);
      apb(1'b0, SPRM_CFG2_ADDR, 32'h0);
      chk("cfg2 read", c2 & 32'h0003_FF01, rd & 32'h0003_FF01);
      apb(1'b0, SPRM_CFG3_ADDR, 32'h0);
      chk("cfg3 read", c3 & 32'h0000_0003, rd & 32'h0000_0003);
      apb(1'b0, SPRM_STAT_ADDR, 32'h0);
      chk("status", 32'(adc_exp(cfg_variant, c2, sl, sh)), rd);
      pins();
    end
    // A second reset must drop every relocation back to the default groups.
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    {c2, c3, sl, sh} = '0;
    pins();
    apb(1'b0, SPRM_CFG3_ADDR, 32'h0);
    chk("cfg3 after reset", 32'h0, rd);
    end_sim();
  end
endmodule : serial_pin_remap_and_adc_routing_tb
